// File: rtl/clcr_pkg.sv
// Purpose: Constants for the closed-loop commutation regulator
// Assumes: Register indices as printed; byte address is index times four
// Notes: Several offsets not multiples of four, so they are indices
package clcr_pkg;
  localparam logic [7:0] IDX_ENC_CONF = 8'h07;
  localparam logic [7:0] IDX_STEP_OUT = 8'h0a;
  localparam logic [7:0] IDX_MAX_ANGLE = 8'h1c;
  localparam logic [7:0] IDX_INT_POS = 8'h21;
  localparam logic [7:0] IDX_ENCODER_POS = 8'h50;
  localparam logic [7:0] IDX_DEVIATION = 8'h52;
  localparam logic [7:0] IDX_CAL_OFFSET = 8'h59;
  localparam logic [7:0] IDX_VCALC_P = 8'h5a;
  localparam logic [7:0] IDX_VCALC_I = 8'h5b;
  localparam logic [7:0] IDX_PGAIN = 8'h5c;
  localparam logic [7:0] IDX_DV_CLIP = 8'h5e;
  localparam logic [7:0] IDX_TOLERANCE = 8'h5f;
  localparam logic [7:0] IDX_CYCLE = 8'h63;
  localparam logic [7:0] IDX_MICROSTEP = 8'h79;
  localparam logic [7:0] IDX_STATUS = 8'h70;
  localparam logic [7:0] IDX_ANGLE = 8'h71;
  localparam logic [7:0] IDX_VLIMIT = 8'h72;
  // Field positions in encoder_input_config (chosen)
  localparam int ENC_INCR_BIT = 0;
  localparam int CAL_EN_BIT = 1;
  localparam int MODE_LO = 2;
  localparam int VLIM_EN_BIT = 4;
  localparam logic [1:0] MODE_CLOSED = 2'h1;
  localparam int CYCLE_LO = 16;
  localparam int GAIN_FRAC = 16;
  localparam logic [15:0] INCR_CYCLE = 16'h0005;
  localparam logic [23:0] GAIN_ONE = 24'h010000;
  localparam logic [31:0] ZERO32 = 32'h00000000;
  localparam logic [8:0] MAX_ANGLE_RST = 9'h000;
  localparam logic [7:0] TOL_RST = 8'h00;
  localparam logic [15:0] CYCLE_RST = 16'h0005;
endpackage : clcr_pkg

// File: rtl/clcr_regulator.sv
// Purpose: Closed-loop commutation regulator with catch-up velocity limit
// Assumes: Positions come from same-clock logic; register port is simple
// Notes: Reads return data one cycle after the read strobe
// Function
// [RULE1] Deviation is internal minus encoder minus offset
// [RULE2] Commutation angle pinned at maximum angle
// [RULE3] Max-angle event when deviation reaches limit
// [RULE4] In-tolerance flag when absolute deviation within tolerance
// [RULE5] Fit event when deviation returns within tolerance
// [RULE6] Gain forced to one within tolerance
// [RULE7] Outside tolerance angle is scaled deviation plus encoder
// [RULE8] Gain is 24 bits, 16 fractional
// [RULE9] Absolute encoder spaces cycles by delay field
// [RULE10] Software keeps cycle no faster than encoder
// [RULE11] Incremental encoder forces five-cycle regulation
// [RULE12] Software sets 256 microsteps before closed loop
// [RULE13] Switch calibration sequence performed by software
// [RULE14] Calibration captures mismatch into offset register
// [RULE15] Switchless calibration: software aligns internal position
// [RULE16] Software may write offset directly
// [RULE17] Catch-up limit is PI on ramp velocity
// [RULE18] Separate P and I catch-up coefficients
// [RULE19] Velocity correction clipped by programmable limit
// [RULE20] Offset kept after calibration enable clears
`timescale 1ns/1ps
module clcr_regulator #(
  parameter int PW = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Motion inputs from ramp and microstep logic
  input wire logic [PW-1:0] rampVelocity,
  input wire logic [9:0] microstepCount,
  // Encoder side
  input wire logic [PW-1:0] encoderPosIn,
  input wire logic encoderPosLoad,
  // Regulator outputs
  output logic [PW-1:0] commutationAngle,
  output logic [PW-1:0] catchupVelocity,
  output logic inToleranceFlag,
  output logic maxAngleEvent,
  output logic fitEvent,
  output logic regulationTick
);
  // Configuration registers
  logic [31:0] encConf_q;
  logic [31:0] stepOutCfg_q;
  logic [8:0] maxAngle_q;
  logic [31:0] vcalcP_q;
  logic [31:0] vcalcI_q;
  logic [23:0] pGain_q;
  logic [31:0] dvClip_q;
  logic [7:0] tol_q;
  logic [15:0] cycle_q;
  // Position state
  logic [31:0] intPos_q;
  logic [31:0] encoderPos_q;
  logic [31:0] calOffset_q;
  // Regulation state
  logic [15:0] cycCnt_q;
  logic [PW-1:0] angle_q;
  logic [PW-1:0] vel_q;
  logic [PW-1:0] iSum_q;
  logic tick_q;
  // Status and events
  logic fit_q;
  logic maxAt_q;
  logic fitEv_q;
  logic maxEv_q;
  // Read data
  logic [31:0] regRdata_q;

  // One index compare shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
    return a == i;
  endfunction : hit

  // Write selects; read-only and unmapped indices select nothing
  wire wrEncConf = regWr && hit(regAddr, clcr_pkg::IDX_ENC_CONF);
  wire wrStepOut = regWr && hit(regAddr, clcr_pkg::IDX_STEP_OUT);
  wire wrMaxAngle = regWr && hit(regAddr, clcr_pkg::IDX_MAX_ANGLE);
  wire wrIntPos = regWr && hit(regAddr, clcr_pkg::IDX_INT_POS);
  wire wrEncoderPos = regWr && hit(regAddr, clcr_pkg::IDX_ENCODER_POS);
  wire wrCalOffset = regWr && hit(regAddr, clcr_pkg::IDX_CAL_OFFSET);
  wire wrVcalcP = regWr && hit(regAddr, clcr_pkg::IDX_VCALC_P);
  wire wrVcalcI = regWr && hit(regAddr, clcr_pkg::IDX_VCALC_I);
  wire wrPGain = regWr && hit(regAddr, clcr_pkg::IDX_PGAIN);
  wire wrDvClip = regWr && hit(regAddr, clcr_pkg::IDX_DV_CLIP);
  wire wrTolerance = regWr && hit(regAddr, clcr_pkg::IDX_TOLERANCE);
  wire wrCycle = regWr && hit(regAddr, clcr_pkg::IDX_CYCLE);

  // Read selects
  wire rdEncConf = hit(regAddr, clcr_pkg::IDX_ENC_CONF);
  wire rdStepOut = hit(regAddr, clcr_pkg::IDX_STEP_OUT);
  wire rdMaxAngle = hit(regAddr, clcr_pkg::IDX_MAX_ANGLE);
  wire rdIntPos = hit(regAddr, clcr_pkg::IDX_INT_POS);
  wire rdEncoderPos = hit(regAddr, clcr_pkg::IDX_ENCODER_POS);
  wire rdDeviation = hit(regAddr, clcr_pkg::IDX_DEVIATION);
  wire rdCalOffset = hit(regAddr, clcr_pkg::IDX_CAL_OFFSET);
  wire rdVcalcP = hit(regAddr, clcr_pkg::IDX_VCALC_P);
  wire rdVcalcI = hit(regAddr, clcr_pkg::IDX_VCALC_I);
  wire rdPGain = hit(regAddr, clcr_pkg::IDX_PGAIN);
  wire rdDvClip = hit(regAddr, clcr_pkg::IDX_DV_CLIP);
  wire rdTolerance = hit(regAddr, clcr_pkg::IDX_TOLERANCE);
  wire rdCycle = hit(regAddr, clcr_pkg::IDX_CYCLE);
  wire rdMicrostep = hit(regAddr, clcr_pkg::IDX_MICROSTEP);
  wire rdStatus = hit(regAddr, clcr_pkg::IDX_STATUS);
  wire rdAngle = hit(regAddr, clcr_pkg::IDX_ANGLE);
  wire rdVlimit = hit(regAddr, clcr_pkg::IDX_VLIMIT);

  // Mode bits of the encoder input configuration
  wire calEn = encConf_q[clcr_pkg::CAL_EN_BIT];
  wire [1:0] modeSel = encConf_q[clcr_pkg::MODE_LO+1 -: 2];
  wire closed = modeSel == clcr_pkg::MODE_CLOSED;
  wire incrEnc = encConf_q[clcr_pkg::ENC_INCR_BIT];
  wire vlimEn = encConf_q[clcr_pkg::VLIM_EN_BIT];
  // Capture runs only while calibration and closed mode are both on
  wire calCapture = calEn && closed;

  // Deviation and tolerance window
  wire signed [31:0] rawDiff = $signed(intPos_q - encoderPos_q);
  wire signed [31:0] offsetS = $signed(calOffset_q);
  wire signed [31:0] deviation = rawDiff - offsetS; // see [RULE1]
  wire [31:0] absDev = deviation[31] ? 32'(-deviation) : 32'(deviation);
  wire [31:0] tolWide = {24'h000000, tol_q};
  wire [31:0] maxWide = {23'h0, maxAngle_q};
  wire inTol = absDev <= tolWide; // see [RULE4]
  wire atMax = absDev >= maxWide; // see [RULE3]

  // Proportional step; the gain carries 16 fractional bits
  wire [23:0] effGain = inTol ? clcr_pkg::GAIN_ONE : pGain_q; // see [RULE6]
  wire signed [24:0] gainS = $signed({1'b0, effGain});
  wire signed [56:0] prod = deviation * gainS; // see [RULE8]
  wire signed [31:0] pTerm = 32'(prod >>> clcr_pkg::GAIN_FRAC);
  wire signed [31:0] maxS = $signed(maxWide);
  // Clipping keeps the angle pinned once the limit is reached
  wire signed [31:0] pClip = (pTerm > maxS) ? maxS :
    (pTerm < -maxS) ? -maxS : pTerm; // see [RULE2]
  wire [31:0] angleNext = encoderPos_q + 32'(pClip); // see [RULE7]
  wire regStep = tickNow && closed;

  // Regulation cycle period
  wire [15:0] period = incrEnc ? clcr_pkg::INCR_CYCLE : cycle_q;
  // Incremental encoder forces the fast rate, see [RULE11]
  wire tickNow = cycCnt_q == 16'h0000; // see [RULE9]
  wire [15:0] reload = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
  wire [15:0] cycNext = tickNow ? reload : cycCnt_q - 16'h0001;

  // Catch-up PI; the integral is not clipped in this block
  wire signed [31:0] pGainV = $signed(vcalcP_q);
  wire signed [31:0] iGainV = $signed(vcalcI_q);
  wire signed [63:0] pPart = deviation * pGainV; // see [RULE18]
  wire signed [63:0] iPart = $signed(iSum_q) * iGainV; // see [RULE18]
  wire signed [63:0] piSum = pPart + iPart;
  wire signed [31:0] dvRaw = 32'(piSum >>> clcr_pkg::GAIN_FRAC);
  wire signed [31:0] clipS = $signed(dvClip_q);
  wire signed [31:0] dv = (dvRaw > clipS) ? clipS :
    (dvRaw < -clipS) ? -clipS : dvRaw; // see [RULE19]
  wire [31:0] dvU = 32'(dv);
  wire [31:0] velNext = vlimEn ? rampVelocity + dvU : rampVelocity;
  // Base velocity is the ramp velocity, see [RULE17]
  wire iHold = vlimEn && !inTol;
  wire [31:0] iSumNext = iHold ? iSum_q + 32'(deviation) : clcr_pkg::ZERO32;

  // Read mux
  wire [31:0] rdMux =
    rdEncConf ? encConf_q :
    rdStepOut ? stepOutCfg_q :
    rdMaxAngle ? maxWide :
    rdIntPos ? intPos_q :
    rdEncoderPos ? encoderPos_q :
    rdDeviation ? 32'(deviation) : // see [RULE1]
    rdCalOffset ? calOffset_q :
    rdVcalcP ? vcalcP_q :
    rdVcalcI ? vcalcI_q :
    rdPGain ? {8'h00, pGain_q} :
    rdDvClip ? dvClip_q :
    rdTolerance ? tolWide :
    rdCycle ? {cycle_q, 16'h0000} :
    rdMicrostep ? {22'h0, microstepCount} :
    rdStatus ? {29'h0, maxAt_q, closed, fit_q} :
    rdAngle ? angle_q :
    rdVlimit ? vel_q : clcr_pkg::ZERO32;

  // Configuration registers, one short process each
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      encConf_q <= clcr_pkg::ZERO32;
    end else if (wrEncConf) begin
      encConf_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stepOutCfg_q <= clcr_pkg::ZERO32;
    end else if (wrStepOut) begin
      stepOutCfg_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      maxAngle_q <= clcr_pkg::MAX_ANGLE_RST;
    end else if (wrMaxAngle) begin
      maxAngle_q <= regWdata[8:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vcalcP_q <= clcr_pkg::ZERO32;
    end else if (wrVcalcP) begin
      vcalcP_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vcalcI_q <= clcr_pkg::ZERO32;
    end else if (wrVcalcI) begin
      vcalcI_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pGain_q <= clcr_pkg::GAIN_ONE;
    end else if (wrPGain) begin
      pGain_q <= regWdata[23:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dvClip_q <= clcr_pkg::ZERO32;
    end else if (wrDvClip) begin
      dvClip_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tol_q <= clcr_pkg::TOL_RST;
    end else if (wrTolerance) begin
      tol_q <= regWdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycle_q <= clcr_pkg::CYCLE_RST;
    end else if (wrCycle) begin
      cycle_q <= regWdata[CYCLE_HI:clcr_pkg::CYCLE_LO];
    end
  end
  localparam int CYCLE_HI = clcr_pkg::CYCLE_LO + 15;

  // Internal position is only ever set by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      intPos_q <= clcr_pkg::ZERO32;
    end else if (wrIntPos) begin
      intPos_q <= regWdata;
    end
  end

  // A software write wins over an encoder load in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      encoderPos_q <= clcr_pkg::ZERO32;
    end else if (wrEncoderPos) begin
      encoderPos_q <= regWdata;
    end else if (encoderPosLoad) begin
      encoderPos_q <= encoderPosIn;
    end
  end

  // Capture wins over a software write, so calibration cannot be undone
  // by a stray write while it runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      calOffset_q <= clcr_pkg::ZERO32;
    end else if (calCapture) begin
      calOffset_q <= 32'(rawDiff); // see [RULE14]
    end else if (wrCalOffset) begin
      calOffset_q <= regWdata; // see [RULE16]
    end
  end
  // Otherwise the offset holds its last captured or written value, see [RULE20]

  // Regulation cycle counter and tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycCnt_q <= clcr_pkg::CYCLE_RST;
      tick_q <= 1'b0;
    end else begin
      cycCnt_q <= cycNext;
      tick_q <= tickNow;
    end
  end

  // Status levels and their one-cycle events
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fit_q <= 1'b1;
    end else begin
      fit_q <= inTol; // see [RULE4]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      maxAt_q <= 1'b0;
    end else begin
      maxAt_q <= atMax;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fitEv_q <= 1'b0;
    end else begin
      fitEv_q <= inTol && !fit_q; // see [RULE5]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      maxEv_q <= 1'b0;
    end else begin
      maxEv_q <= atMax && !maxAt_q; // see [RULE3]
    end
  end

  // Angle, catch-up velocity and integral move only on a tick in closed mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      angle_q <= clcr_pkg::ZERO32;
    end else if (regStep) begin
      angle_q <= angleNext; // see [RULE7]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vel_q <= clcr_pkg::ZERO32;
    end else if (regStep) begin
      vel_q <= velNext; // see [RULE17]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      iSum_q <= clcr_pkg::ZERO32;
    end else if (regStep) begin
      iSum_q <= iSumNext;
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regRdata_q <= clcr_pkg::ZERO32;
    end else begin
      regRdata_q <= regRd ? rdMux : clcr_pkg::ZERO32;
    end
  end

  assign regRdata = regRdata_q;
  assign commutationAngle = angle_q;
  assign catchupVelocity = vel_q;
  assign inToleranceFlag = fit_q;
  assign maxAngleEvent = maxEv_q;
  assign fitEvent = fitEv_q;
  assign regulationTick = tick_q;
endmodule : clcr_regulator

// File: test/clcr_properties.sv
// Purpose: Port-level properties of the commutation regulator
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the regulator
`timescale 1ns/1ps
module clcr_properties #(
  parameter int PW = 32
) (
  // Clock and register port
  input wire logic clock,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Regulator outputs
  input wire logic [PW-1:0] commutationAngle,
  input wire logic inToleranceFlag,
  input wire logic maxAngleEvent,
  input wire logic fitEvent,
  input wire logic regulationTick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_lone_read;
    regRd ##1 !regRd;
  endsequence
  a_read_slot: assert property (
    regRdata != 32'h0 |-> $past(regRd))
    else $error("read data outside its slot");
  a_read_stands: assert property (
    s_lone_read |=> regRdata == 32'h0)
    else $error("read data held too long");
  a_write_quiet: assert property (
    regWr |=> regRdata == 32'h0)
    else $error("write produced read data");
  a_fit_pulse: assert property (
    fitEvent |=> !fitEvent)
    else $error("fit event longer than one cycle");
  a_fit_in_tol: assert property (
    fitEvent |-> inToleranceFlag)
    else $error("fit event outside tolerance");
  a_max_pulse: assert property (
    maxAngleEvent |=> !maxAngleEvent)
    else $error("max angle event longer than one cycle");
  a_angle_on_tick: assert property (
    $changed(commutationAngle) |-> regulationTick || $past(regulationTick))
    else $error("angle moved without a regulation tick");
  a_reset_values: assert property (
    !$past(rst_n) |-> inToleranceFlag &&
    !maxAngleEvent && !fitEvent && !regulationTick)
    else $error("outputs wrong after reset");
endmodule : clcr_properties

bind clcr_regulator clcr_properties #(.PW(PW)) chk_u (.clock(clock),
  .rst_n(rst_n), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .commutationAngle(commutationAngle), .inToleranceFlag(inToleranceFlag),
  .maxAngleEvent(maxAngleEvent), .fitEvent(fitEvent),
  .regulationTick(regulationTick));

// File: test/tb_clcr_regulator.sv
// Purpose: Self-checking bench for the commutation regulator
// Assumes: Ramp velocity zero until the velocity test drives 1000; encoder loaded by strobe
// Notes: Tick spacing measured by a free-running cycle counter
`timescale 1ns/1ps
module tb_clcr_regulator;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic encoderPosLoad = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [9:0] microstepCount = 10'h080;
  logic [31:0] regWdata = 32'h0, encoderPosIn = 32'h0, regRdata, angle;
  logic inTol, maxEv, fitEv, tick;
  logic [31:0] rampVel = 32'h0, vel;
  int cyc = 0, lastT = 0, gap = 0, nFit = 0, nMax = 0;
  int mismatches = 0, total_checks = 0;
  clcr_regulator dut_u (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rampVelocity(rampVel), .microstepCount(microstepCount),
    .encoderPosIn(encoderPosIn), .encoderPosLoad(encoderPosLoad),
    .commutationAngle(angle), .catchupVelocity(vel), .inToleranceFlag(inTol),
    .maxAngleEvent(maxEv), .fitEvent(fitEv), .regulationTick(tick));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (fitEv === 1'b1) nFit <= nFit + 1;
    if (maxEv === 1'b1) nMax <= nMax + 1;
    if (tick === 1'b1) begin
      gap <= cyc - lastT;
      lastT <= cyc;
    end
    if (cyc > 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    // An edge passes so the next strobe is a fresh assignment
    @(posedge clock);
  endtask : wr
  task automatic rc(string n, logic [7:0] a, logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(n, regRdata, e);
    @(posedge clock);
  endtask : rc
  task automatic enc(logic [31:0] v);
    encoderPosIn <= v;
    encoderPosLoad <= 1'b1;
    @(posedge clock);
    encoderPosLoad <= 1'b0;
    @(posedge clock);
  endtask : enc
  task automatic t_regs();
    rc("gain", clcr_pkg::IDX_PGAIN, 32'h00010000);
    rc("cycle", clcr_pkg::IDX_CYCLE, 32'h00050000);
    wr(8'h5f, 32'h1ff);
    rc("tolerance", 8'h5f, 32'h000000ff);
    rc("unmapped", 8'h3f, 32'h0);
    rc("microstep", 8'h79, 32'h00000080);
  endtask : t_regs
  task automatic t_dev_tol();
    int n;
    wr(8'h21, 32'd100);
    enc(32'd40);
    wr(8'h52, 32'h5);
    rc("deviation", 8'h52, 32'd60);
    wr(8'h5f, 32'h8);
    repeat (3) @(posedge clock);
    chk("flag out", inTol, 1'b0);
    n = nFit;
    wr(8'h21, 32'd45);
    repeat (3) @(posedge clock);
    chk("flag in", inTol, 1'b1);
    chk("fit count", nFit, n + 1);
  endtask : t_dev_tol
  task automatic t_angle();
    int m;
    wr(8'h0a, 32'h0);
    wr(8'h07, 32'h4);
    wr(8'h5f, 32'h0);
    wr(8'h1c, 32'd16);
    m = nMax;
    wr(8'h21, 32'd100);
    repeat (12) @(posedge clock);
    chk("clipped", angle, 32'd56);
    chk("max event", nMax, m + 1);
    wr(8'h1c, 32'h1ff);
    wr(8'h5c, 32'h8000);
    repeat (12) @(posedge clock);
    chk("half gain", angle, 32'd70);
    wr(8'h5f, 32'd200);
    repeat (12) @(posedge clock);
    chk("unit gain", angle, 32'd100);
  endtask : t_angle
  task automatic t_cycle();
    wr(8'h63, 32'h00090000);
    wr(8'h07, 32'h5);
    repeat (20) @(posedge clock);
    chk("incr gap", gap, 32'd5);
    wr(8'h07, 32'h4);
    repeat (30) @(posedge clock);
    chk("abs gap", gap, 32'd9);
  endtask : t_cycle
  task automatic t_cal();
    wr(8'h07, 32'h6);
    repeat (3) @(posedge clock);
    rc("cal dev", 8'h52, 32'h0);
    wr(8'h07, 32'h4);
    enc(32'd50);
    rc("kept offset", 8'h59, 32'd60);
    rc("new dev", 8'h52, 32'hfffffff6);
    wr(8'h59, 32'd20);
    rc("set offset", 8'h59, 32'd20);
    wr(8'h21, 32'h80);
    rc("aligned dev", 8'h52, 32'd58);
  endtask : t_cal
  task automatic t_vel();
    rampVel <= 32'd1000;
    wr(8'h5a, 32'h10000);
    wr(8'h5b, 32'h0);
    wr(8'h5e, 32'd20);
    wr(8'h07, 32'h14);
    repeat (12) @(posedge clock);
    chk("clipped vel", vel, 32'd1020);
    wr(8'h5e, 32'd100);
    repeat (12) @(posedge clock);
    chk("ramp plus p", vel, 32'd1058);
  endtask : t_vel
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_dev_tol();
    t_angle();
    t_cycle();
    t_cal();
    t_vel();
    summarize();
  end
endmodule : tb_clcr_regulator
